// File: hw/tgc_cfg.svh
// tgc_cfg.svh: offsets, field positions, reset values for the timer gate control block
// assumes: included by bare name from the package, the top module, the checker and the test
`ifndef TGC_CFG_SVH
`define TGC_CFG_SVH
`define TGC_ADDR_W        12
`define TGC_OFS_A         12'hFCF
`define TGC_OFS_B         12'hFC9
`define TGC_OFS_C         12'hFC3
`define TGC_BIT_GATE_EN   7
`define TGC_BIT_GATE_POL  6
`define TGC_BIT_TOGGLE    5
`define TGC_BIT_SINGLE    4
`define TGC_BIT_ACQ       3
`define TGC_BIT_LEVEL     2
`define TGC_CTRL_RST      5'h00
`define TGC_NUM_TMR       3
`endif

// File: hw/tgc_gate_unit.sv
// tgc_gate_unit.sv: gate processing for one timer (polarity, toggle, single pulse)
// assumes: gate_in already synchronised to clk_in; por_n_in asynchronous power-on reset
module tgc_gate_unit (
  input  wire logic               clk_in,
  input  wire logic               por_n_in,
  input  wire logic               rst_n_in,
  input  wire tgc_pkg::tgc_ctrl_s ctrl_in,
  input  wire logic               on_in,
  input  wire logic               gate_in,
  output logic                    done_clr_out,
  output logic                    count_en_out,
  output logic                    level_out
);
  logic            pol_gate;
  logic            pol_gate_d_r;
  logic            tog_r;
  logic            proc_gate;
  logic            rise;
  tgc_pkg::tgc_sp_e sp_r;
  tgc_pkg::tgc_sp_e sp_nxt;

  assign pol_gate = ctrl_in.polarity ? gate_in : ~gate_in; // R2
  assign rise     = pol_gate & ~pol_gate_d_r;

  always_ff @(posedge clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      pol_gate_d_r <= 1'b0;
    end else begin
      pol_gate_d_r <= pol_gate;
    end
  end

  // toggle flip-flop is held clear while toggle mode is off
  always_ff @(posedge clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      tog_r <= 1'b0;
    end else if (!ctrl_in.toggle_mode) begin
      tog_r <= 1'b0; // R4
    end else if (rise) begin
      tog_r <= ~tog_r; // R3
    end
  end

  assign proc_gate = ctrl_in.toggle_mode ? tog_r : pol_gate;

  // single pulse: arm on acquire, open at next rising edge of the gate (toggle mode: at once if the toggled gate is high), close at its end
  always_comb begin
    sp_nxt = sp_r;
    unique case (sp_r)
      tgc_pkg::TGC_SP_IDLE: begin
        if (ctrl_in.single_pulse_mode && ctrl_in.acquire_status) begin
          sp_nxt = (proc_gate && !ctrl_in.toggle_mode) ? sp_r : tgc_pkg::TGC_SP_ARMED;
        end
      end
      tgc_pkg::TGC_SP_ARMED: begin
        if (!ctrl_in.single_pulse_mode || !ctrl_in.acquire_status) begin
          sp_nxt = tgc_pkg::TGC_SP_IDLE;
        end else if (proc_gate) begin
          sp_nxt = tgc_pkg::TGC_SP_RUN;
        end
      end
      tgc_pkg::TGC_SP_RUN: begin
        if (!ctrl_in.single_pulse_mode || !proc_gate) begin
          sp_nxt = tgc_pkg::TGC_SP_IDLE;
        end
      end
      default: sp_nxt = tgc_pkg::TGC_SP_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      sp_r <= tgc_pkg::TGC_SP_IDLE;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // end of the captured pulse ends the acquisition
  assign done_clr_out = (sp_r == tgc_pkg::TGC_SP_RUN) && (sp_nxt == tgc_pkg::TGC_SP_IDLE);

  always_comb begin
    level_out = ctrl_in.single_pulse_mode ? (sp_r == tgc_pkg::TGC_SP_RUN) // R5
                                          : proc_gate; // R8
    count_en_out = on_in && rst_n_in && (!ctrl_in.enable || level_out); // R1
  end
endmodule

// File: hw/tgc_pkg.sv
// tgc_pkg.sv: types shared by the timer gate control files
// assumes: nothing beyond the cfg header
`include "tgc_cfg.svh"
package tgc_pkg;
  typedef struct packed {
    logic enable;
    logic polarity;
    logic toggle_mode;
    logic single_pulse_mode;
    logic acquire_status;
  } tgc_ctrl_s;
  typedef enum logic [2:0] {
    TGC_SP_IDLE  = 3'b001,
    TGC_SP_ARMED = 3'b010,
    TGC_SP_RUN   = 3'b100
  } tgc_sp_e;
endpackage

// File: hw/tgc_top.sv
// tgc_top.sv: timer gate control for three timers with their control registers
// assumes: a simple register port master on CLK_IN; gate pins asynchronous to CLK_IN
// Contract
// R1: gate enable selects gated or free counting
// R2: polarity picks high or low gate
// R3: toggle mode divides gate by rising edges
// R4: toggle bit cleared also clears toggle flop
// R5: single pulse mode drives the gate
// R6: clearing single pulse clears acquire status
// R7: control bits clear only on power-on reset
// R8: gate level bit reads processed gate
`include "tgc_cfg.svh"
module tgc_top (
  input  wire logic                      CLK_IN,
  input  wire logic                      ARST_N_IN,
  input  wire logic                      SOFT_RST_N_IN,
  input  wire logic [`TGC_ADDR_W-1:0]    ADDR_IN,
  input  wire logic [7:0]                WDATA_IN,
  input  wire logic                      WR_IN,
  input  wire logic                      RD_IN,
  input  wire logic [`TGC_NUM_TMR-1:0]   TIMER_ON_IN,
  input  wire logic [`TGC_NUM_TMR-1:0]   GATE_IN,
  output logic      [7:0]                RDATA_OUT,
  output logic      [`TGC_NUM_TMR-1:0]   COUNT_EN_OUT
);
  localparam int N = `TGC_NUM_TMR;

  tgc_pkg::tgc_ctrl_s   ctrl_r [N];
  logic [N-1:0]         gate_s1_r;
  logic [N-1:0]         gate_s2_r;
  logic                 soft_s1_r;
  logic                 soft_s2_r;
  logic [N-1:0]         done_clr;
  logic [N-1:0]         level;
  logic [N-1:0]         count_en;

  // map a bus address to a timer index; returns N when unmapped
  function automatic logic [1:0] tgc_decode(input logic [`TGC_ADDR_W-1:0] a);
    logic [1:0] idx;
    idx = 2'h3;
    if (a == `TGC_OFS_A) idx = 2'h0;
    if (a == `TGC_OFS_B) idx = 2'h1;
    if (a == `TGC_OFS_C) idx = 2'h2;
    return idx;
  endfunction

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      gate_s1_r <= '0;
      gate_s2_r <= '0;
      soft_s1_r <= 1'b0;
      soft_s2_r <= 1'b0;
    end else begin
      gate_s1_r <= GATE_IN;
      gate_s2_r <= gate_s1_r;
      soft_s1_r <= SOFT_RST_N_IN;
      soft_s2_r <= soft_s1_r;
    end
  end

  // only the power-on reset touches the control bits; a soft reset leaves them as they are
  for (genvar i = 0; i < N; i++) begin : g_tmr
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
        ctrl_r[i] <= `TGC_CTRL_RST; // R7
      end else begin
        if (WR_IN && tgc_decode(ADDR_IN) == 2'(i)) begin
          ctrl_r[i].enable            <= WDATA_IN[`TGC_BIT_GATE_EN];
          ctrl_r[i].polarity          <= WDATA_IN[`TGC_BIT_GATE_POL];
          ctrl_r[i].toggle_mode       <= WDATA_IN[`TGC_BIT_TOGGLE];
          ctrl_r[i].single_pulse_mode <= WDATA_IN[`TGC_BIT_SINGLE];
          ctrl_r[i].acquire_status    <= WDATA_IN[`TGC_BIT_ACQ] & WDATA_IN[`TGC_BIT_SINGLE];
        end else if (!ctrl_r[i].single_pulse_mode) begin
          ctrl_r[i].acquire_status    <= 1'b0; // R6
        end else if (done_clr[i]) begin
          ctrl_r[i].acquire_status    <= 1'b0;
        end
      end
    end

    tgc_gate_unit u_gate (
      .clk_in       (CLK_IN),
      .por_n_in     (ARST_N_IN),
      .rst_n_in     (soft_s2_r),
      .ctrl_in      (ctrl_r[i]),
      .on_in        (TIMER_ON_IN[i]),
      .gate_in      (gate_s2_r[i]),
      .done_clr_out (done_clr[i]),
      .count_en_out (count_en[i]),
      .level_out    (level[i])
    );
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      COUNT_EN_OUT <= '0;
    end else begin
      COUNT_EN_OUT <= count_en; // R1
    end
  end

  // read data is valid only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_IN && tgc_decode(ADDR_IN) != 2'h3) begin
      RDATA_OUT <= {ctrl_r[tgc_decode(ADDR_IN)], level[tgc_decode(ADDR_IN)], 2'b00}; // R8
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end
endmodule

// File: test/tgc_checker.sv
// tgc_checker.sv: port assertions on timer a of tgc_top
// assumes: bound to tgc_top; a shadow of control a follows bus writes
`include "tgc_cfg.svh"
module tgc_checker (
  input wire logic                    CLK_IN,
  input wire logic                    ARST_N_IN,
  input wire logic                    SOFT_RST_N_IN,
  input wire logic [`TGC_ADDR_W-1:0]  ADDR_IN,
  input wire logic [7:0]              WDATA_IN,
  input wire logic                    WR_IN,
  input wire logic                    RD_IN,
  input wire logic [`TGC_NUM_TMR-1:0] TIMER_ON_IN,
  input wire logic [`TGC_NUM_TMR-1:0] GATE_IN,
  input wire logic [7:0]              RDATA_OUT,
  input wire logic [`TGC_NUM_TMR-1:0] COUNT_EN_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sa_r;
  logic       rq_r;
  wire        k = TIMER_ON_IN[0] & SOFT_RST_N_IN;
  wire        g = sa_r[7] && sa_r[5:4] == 2'h0 && k;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN) sa_r <= 8'h00;
    else if (WR_IN && ADDR_IN == `TGC_OFS_A) sa_r <= WDATA_IN;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN) rq_r <= 1'h0;
    else rq_r <= RD_IN && ADDR_IN == `TGC_OFS_A;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // windows of 5 to 6 cycles cover the two-flop synchronisers
  chk_free_count: assert property ((!sa_r[7] && k)[*5] |=> COUNT_EN_OUT[0])
    else $error("free count lost");
  chk_gate_on: assert property ((g && GATE_IN[0] == sa_r[6])[*6] |=> COUNT_EN_OUT[0])
    else $error("active gate not counting");
  chk_gate_off: assert property ((g && GATE_IN[0] != sa_r[6])[*6] |=> !COUNT_EN_OUT[0])
    else $error("idle gate counting");
  chk_toggle_hold: assert property
    (($stable(GATE_IN[0]) && sa_r[7:4] == 4'hE && k)[*6] |=> $stable(COUNT_EN_OUT[0]))
    else $error("toggle moved without edge");
  chk_pulse_idle: assert property ((sa_r[7] && sa_r[4:3] == 2'h2 && k)[*6] |=> !COUNT_EN_OUT[0])
    else $error("single pulse counting unarmed");
  chk_status_clr: assert property (rq_r && !sa_r[4] |-> !RDATA_OUT[3])
    else $error("status kept without single pulse");
  chk_ctrl_keep: assert property (rq_r |-> RDATA_OUT[7:4] == sa_r[7:4])
    else $error("control bits lost");
  chk_low_zero: assert property (rq_r |-> RDATA_OUT[1:0] == 2'h0)
    else $error("read-only low bits set");
  cover property (rq_r && RDATA_OUT[3]);
  cover property ($rose(COUNT_EN_OUT[0]) && sa_r[5]);
  cover property (!SOFT_RST_N_IN && sa_r[7]);
endmodule
bind tgc_top tgc_checker i_tgc_checker (.CLK_IN, .ARST_N_IN, .SOFT_RST_N_IN, .ADDR_IN,
  .WDATA_IN, .WR_IN, .RD_IN, .TIMER_ON_IN, .GATE_IN, .RDATA_OUT, .COUNT_EN_OUT);

// File: test/tgc_gate_src.sv
// tgc_gate_src.sv: gate pin source for the three timers
// assumes: inputs change by non-blocking assignment at the rising edge
module tgc_gate_src (
  input  wire logic       clk_in,
  input  wire logic [2:0] lvl_in,
  input  wire logic [3:0] lag_in,
  output logic      [2:0] gate_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_r = 4'h0;
  initial gate_out = 3'h0;
  // a slow source keeps the old level for lag_in cycles
  always @(posedge clk_in) begin
    wait_r <= (lvl_in == gate_out) ? 4'h0 : wait_r + 4'h1;
    if (lvl_in != gate_out && wait_r >= lag_in) gate_out <= lvl_in;
  end
endmodule

// File: test/timer_gate_control_test.sv
// timer_gate_control_test.sv: self-checking bench for tgc_top
// assumes: tgc_gate_src drives the gate pins
`include "tgc_cfg.svh"
module timer_gate_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] w; logic g; logic on; logic en;} tgc_row_s;
  tgc_row_s rows [8] = '{'{8'h00, 1'h0, 1'h1, 1'h1}, '{8'h00, 1'h0, 1'h0, 1'h0},
    '{8'h80, 1'h0, 1'h0, 1'h0}, '{8'h80, 1'h0, 1'h1, 1'h1}, '{8'h80, 1'h1, 1'h1, 1'h0},
    '{8'hC0, 1'h1, 1'h1, 1'h1}, '{8'hC0, 1'h0, 1'h1, 1'h0}, '{8'h90, 1'h0, 1'h1, 1'h0}};
  logic clk = 1'h0, arst_n = 1'h0, srst_n = 1'h1, wr = 1'h0, rd = 1'h0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdat = 8'h00, rdat, q;
  logic [2:0] on = 3'h7, lvl = 3'h0, gate, en;
  logic [3:0] lag = 4'h0;
  int errors = 0, check_count = 0;
  always #12.5 clk = ~clk;
  tgc_top i_tgc_top (.CLK_IN(clk), .ARST_N_IN(arst_n), .SOFT_RST_N_IN(srst_n),
    .ADDR_IN(addr), .WDATA_IN(wdat), .WR_IN(wr), .RD_IN(rd), .TIMER_ON_IN(on),
    .GATE_IN(gate), .RDATA_OUT(rdat), .COUNT_EN_OUT(en));
  tgc_gate_src i_tgc_gate_src (.clk_in(clk), .lvl_in(lvl), .lag_in(lag), .gate_out(gate));
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) {wr, addr, wdat} <= {1'h1, a, d};
    @(posedge clk) wr <= 1'h0;
  endtask
  task rd_reg(input logic [11:0] a);
    @(posedge clk) {rd, addr} <= {1'h1, a};
    @(posedge clk) rd <= 1'h0;
    @(negedge clk) q = rdat;
  endtask
  task gt(input logic l, input logic e);
    @(posedge clk) lvl <= {3{l}};
    repeat (14) @(posedge clk);
    @(negedge clk) chk("count", 8'(e), 8'(en[0]));
  endtask
  task tally_and_finish;
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'h1;
    foreach (rows[i]) begin
      @(posedge clk) {on[0], lvl} <= {rows[i].on, {3{rows[i].g}}};
      wr_reg(`TGC_OFS_A, rows[i].w);
      gt(rows[i].g, rows[i].en);
      rd_reg(`TGC_OFS_A);
      chk("ctrl", rows[i].w & 8'hFB, q & 8'hFB);
    end
    lag = 4'h5;
    wr_reg(`TGC_OFS_A, 8'hE0);
    gt(1'h0, 1'h0);
    gt(1'h1, 1'h1);
    gt(1'h0, 1'h1);
    gt(1'h1, 1'h0);
    gt(1'h0, 1'h0);
    gt(1'h1, 1'h1);
    wr_reg(`TGC_OFS_A, 8'hC0);
    wr_reg(`TGC_OFS_A, 8'hE0);
    gt(1'h1, 1'h0);
    wr_reg(`TGC_OFS_A, 8'hD8);
    gt(1'h0, 1'h0);
    gt(1'h1, 1'h1);
    gt(1'h0, 1'h0);
    rd_reg(`TGC_OFS_A);
    chk("done", 8'hD0, q & 8'hF8);
    gt(1'h1, 1'h0);
    wr_reg(`TGC_OFS_A, 8'hD8);
    rd_reg(`TGC_OFS_A);
    chk("armed", 8'hD8, q & 8'hF8);
    wr_reg(`TGC_OFS_A, 8'hC8);
    rd_reg(`TGC_OFS_A);
    chk("status", 8'hC0, q & 8'hF8);
    for (int l = 0; l < 2; l++) begin
      gt(l[0], l[0]);
      rd_reg(`TGC_OFS_A);
      chk("level", 8'(l[0]), 8'(q[2]));
    end
    wr_reg(`TGC_OFS_B, 8'h40);
    wr_reg(`TGC_OFS_C, 8'h20);
    @(posedge clk) srst_n <= 1'h0;
    repeat (4) @(posedge clk);
    @(negedge clk) chk("soft en", 8'h00, 8'(en));
    @(posedge clk) srst_n <= 1'h1;
    rd_reg(`TGC_OFS_B);
    chk("soft b", 8'h40, q & 8'hF8);
    rd_reg(`TGC_OFS_C);
    chk("soft c", 8'h20, q & 8'hF8);
    chk("soft end", 8'h07, 8'(en));
    @(posedge clk) arst_n <= 1'h0;
    @(posedge clk) arst_n <= 1'h1;
    rd_reg(`TGC_OFS_A);
    chk("por", 8'h00, q & 8'hFB);
    rd_reg(12'h000);
    chk("unmapped", 8'h00, q);
    tally_and_finish;
  end
endmodule
